// File: dv/pin_drv.sv
// External pin sources: irq zero, irq one and count pin, idle high
`timescale 1ns/1ps
module pin_drv (
  // Clock
  input wire logic clk_i,
  // Pins
  output logic [2:0] pin_o
);
  initial pin_o = 3'h7;
  // Move pin n to v after an edge, then hold it c cycles
  task automatic drive(input int n, input logic v, input int c);
    @(posedge clk_i);
    pin_o[n] <= v;
    repeat (c) @(posedge clk_i);
  endtask : drive
endmodule : pin_drv

// File: dv/tb.sv
// Self-checking bench for the timer gate and external interrupt inputs
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] pin;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hready;
  logic irq;
  logic hresp;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  pin_drv pins (.clk_i(clk), .pin_o(pin));
  tmr_pins dut (.REF_CLK_I(clk), .RST_I(rst), .EXT_IRQ_ZERO_PIN_I(pin[0]), .EXT_IRQ_ONE_PIN_I(pin[1]),
    .TIMER_ZERO_COUNT_PIN_I(pin[2]), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .IRQ_O(irq));
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One single word transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    xfer(1'b0, ad, 32'h0);
    check(rd, exp);
    check({31'h0, hresp}, 32'h0);
  endtask : rchk
  task automatic irqchk(input logic e);
    #1;
    check({31'h0, irq}, {31'h0, e});
  endtask : irqchk
  // Count must stand with the gate pin low and advance one per clock when high
  task automatic gate(input int n, input logic [7:0] ad);
    logic [31:0] a;
    for (int v = 0; v < 2; v++) begin
      pins.drive(n, v[0], 4);
      xfer(1'b0, ad, 32'h0);
      a = rd;
      repeat (10) @(posedge clk);
      xfer(1'b0, ad, 32'h0);
      check(rd - a, v ? 32'd13 : 32'd0);
    end
  endtask : gate
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rchk(8'(i * 4), 32'h0);
    xfer(1'b1, 8'h14, 32'hffff_ffff);
    rchk(8'h14, 32'h0);
    // Level trigger, masked then unmasked
    pins.drive(0, 1'b0, 4);
    irqchk(1'b0);
    xfer(1'b1, tmr_pins_pkg::MASK_OFS, 32'h3);
    irqchk(1'b1);
    pins.drive(0, 1'b1, 4);
    rchk(tmr_pins_pkg::STAT_OFS, 32'h1);
    rchk(tmr_pins_pkg::STAT_OFS, 32'h0);
    irqchk(1'b0);
    pins.drive(1, 1'b0, 4);
    pins.drive(1, 1'b1, 4);
    rchk(tmr_pins_pkg::STAT_OFS, 32'h2);
    // Edge trigger: a held low level must not set it again
    xfer(1'b1, tmr_pins_pkg::CTRL_OFS, 32'h30);
    pins.drive(0, 1'b0, 6);
    rchk(tmr_pins_pkg::STAT_OFS, 32'h1);
    rchk(tmr_pins_pkg::STAT_OFS, 32'h0);
    pins.drive(0, 1'b1, 4);
    pins.drive(1, 1'b0, 1);
    pins.drive(1, 1'b1, 5);
    rchk(tmr_pins_pkg::STAT_OFS, 32'h2);
    // Gated run of both timers
    xfer(1'b1, tmr_pins_pkg::CTRL_OFS, 32'h0f);
    gate(0, tmr_pins_pkg::CNT0_OFS);
    gate(1, tmr_pins_pkg::CNT1_OFS);
    rchk(tmr_pins_pkg::STAT_OFS, 32'h3);
    // Counter mode on the count pin
    xfer(1'b1, tmr_pins_pkg::CTRL_OFS, 32'h41);
    xfer(1'b1, tmr_pins_pkg::CNT0_OFS, 32'h0);
    for (int i = 0; i < 5; i++) begin
      pins.drive(2, 1'b0, 3);
      pins.drive(2, 1'b1, 3);
    end
    repeat (4) @(posedge clk);
    rchk(tmr_pins_pkg::CNT0_OFS, 32'h5);
    // Timer one wraps and flags it
    xfer(1'b1, tmr_pins_pkg::CNT1_OFS, 32'hfffe);
    xfer(1'b1, tmr_pins_pkg::CTRL_OFS, 32'h02);
    repeat (4) @(posedge clk);
    rchk(tmr_pins_pkg::STAT_OFS, 32'h8);
    summarize();
  end
endmodule : tb

// File: rtl/pin_sync.sv
// Two-stage synchroniser with falling edge detect for one pin
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Pin and results
  input wire logic pin_i,
  output logic level_o,
  output logic fall_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // First flop feeds only the second
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign fall_o = prev_r & ~sync_r;

  a_fall_shape: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    fall_o |-> $past(sync_r) && !sync_r)
    else $error("edge flagged without high then low");
endmodule : pin_sync

// File: rtl/tmr_pins.sv
// Timer gate, counter pin and external interrupt input logic with AHB-Lite registers
`timescale 1ns/1ps
module tmr_pins #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Pins
  input wire logic EXT_IRQ_ZERO_PIN_I,
  input wire logic EXT_IRQ_ONE_PIN_I,
  input wire logic TIMER_ZERO_COUNT_PIN_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // Interrupt
  output logic IRQ_O
);
  logic irq0_lvl;
  logic irq0_fall;
  logic irq1_lvl;
  logic irq1_fall;
  logic t0_lvl;
  logic t0_fall;
  logic [tmr_pins_pkg::CTRL_W-1:0] ctrl_r;
  logic [tmr_pins_pkg::STAT_W-1:0] stat_r;
  logic [tmr_pins_pkg::STAT_W-1:0] mask_r;
  logic [CNT_W-1:0] cnt0_r;
  logic [CNT_W-1:0] cnt1_r;
  logic run0;
  logic run1;
  logic tick0;
  logic set_pend0;
  logic set_pend1;
  logic ovf0;
  logic ovf1;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic rd_stat;
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;
  logic addr_ok;
  logic [tmr_pins_pkg::STAT_W-1:0] stat_set;

  // Data-phase write strobe for one register
  function automatic logic wr_hit(input logic pend, input logic [7:0] wa, input logic [7:0] ofs);
    return pend && (wa == ofs);
  endfunction : wr_hit

  // All sampling runs on the oscillator clock
  pin_sync u_sync_irq0 (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .pin_i(EXT_IRQ_ZERO_PIN_I),
    .level_o(irq0_lvl), .fall_o(irq0_fall));
  pin_sync u_sync_irq1 (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .pin_i(EXT_IRQ_ONE_PIN_I),
    .level_o(irq1_lvl), .fall_o(irq1_fall));
  pin_sync u_sync_t0 (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .pin_i(TIMER_ZERO_COUNT_PIN_I),
    .level_o(t0_lvl), .fall_o(t0_fall));

  // Gate: pin high lets the timer run
  assign run0 = ctrl_r[tmr_pins_pkg::RUN0_BIT] &
    (~ctrl_r[tmr_pins_pkg::TIMER_ZERO_GATING_SEL_SEL_BIT] | irq0_lvl);
  assign run1 = ctrl_r[tmr_pins_pkg::RUN1_BIT] &
    (~ctrl_r[tmr_pins_pkg::TIMER_ONE_GATING_SEL_SEL_BIT] | irq1_lvl);
  // Counter mode counts falling pin edges, else every clock
  assign tick0 = ctrl_r[tmr_pins_pkg::CNT0_MODE_BIT] ? t0_fall : 1'b1;

  assign set_pend0 = ctrl_r[tmr_pins_pkg::TRIG0_SEL_BIT] ? irq0_fall : ~irq0_lvl;
  assign set_pend1 = ctrl_r[tmr_pins_pkg::TRIG1_SEL_BIT] ? irq1_fall : ~irq1_lvl;
  assign ovf0 = run0 & tick0 & (&cnt0_r);
  assign ovf1 = run1 & (&cnt1_r);

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      cnt0_r <= '0;
    end else if (wr_hit(wr_pend_r, wr_addr_r, tmr_pins_pkg::CNT0_OFS)) begin
      cnt0_r <= HWDATA_I[CNT_W-1:0];
    end else if (run0 && tick0) begin
      cnt0_r <= cnt0_r + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      cnt1_r <= '0;
    end else if (wr_hit(wr_pend_r, wr_addr_r, tmr_pins_pkg::CNT1_OFS)) begin
      cnt1_r <= HWDATA_I[CNT_W-1:0];
    end else if (run1) begin
      cnt1_r <= cnt1_r + 1'b1;
    end
  end

  // AHB-Lite: zero wait states, writes land in data phase
  assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok & HWRITE_I;
      wr_addr_r <= HADDR_I[7:0];
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ctrl_r <= tmr_pins_pkg::CTRL_RST;
    end else if (wr_hit(wr_pend_r, wr_addr_r, tmr_pins_pkg::CTRL_OFS)) begin
      ctrl_r <= HWDATA_I[tmr_pins_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      mask_r <= tmr_pins_pkg::MASK_RST;
    end else if (wr_hit(wr_pend_r, wr_addr_r, tmr_pins_pkg::MASK_OFS)) begin
      mask_r <= HWDATA_I[tmr_pins_pkg::STAT_W-1:0];
    end
  end

  assign rd_stat = addr_ok && !HWRITE_I && HADDR_I[7:0] == tmr_pins_pkg::STAT_OFS;
  assign stat_set = {ovf1, ovf0, set_pend1, set_pend0};

  // Read clears, a new event in the same cycle survives
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      stat_r <= tmr_pins_pkg::STAT_RST;
    end else begin
      stat_r <= (rd_stat ? '0 : stat_r) | stat_set;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (HADDR_I[7:0])
      tmr_pins_pkg::CTRL_OFS: rdata_nxt[tmr_pins_pkg::CTRL_W-1:0] = ctrl_r;
      tmr_pins_pkg::STAT_OFS: rdata_nxt[tmr_pins_pkg::STAT_W-1:0] = stat_r;
      tmr_pins_pkg::MASK_OFS: rdata_nxt[tmr_pins_pkg::STAT_W-1:0] = mask_r;
      tmr_pins_pkg::CNT0_OFS: rdata_nxt[CNT_W-1:0] = cnt0_r;
      tmr_pins_pkg::CNT1_OFS: rdata_nxt[CNT_W-1:0] = cnt1_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      rdata_r <= 32'h0000_0000;
    end else if (addr_ok && !HWRITE_I) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign HRDATA_O = rdata_r;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign IRQ_O = |(stat_r & mask_r);

  a_lvl_pend0: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !ctrl_r[tmr_pins_pkg::TRIG0_SEL_BIT] && !irq0_lvl |=> stat_r[tmr_pins_pkg::PEND0_BIT])
    else $error("low level did not set pending zero");
  a_edge_pend0: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ctrl_r[tmr_pins_pkg::TRIG0_SEL_BIT] && irq0_fall |=> stat_r[tmr_pins_pkg::PEND0_BIT])
    else $error("falling edge did not set pending zero");
  a_lvl_pend1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !ctrl_r[tmr_pins_pkg::TRIG1_SEL_BIT] && !irq1_lvl |=> stat_r[tmr_pins_pkg::PEND1_BIT])
    else $error("low level did not set pending one");
  a_edge_pend1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ctrl_r[tmr_pins_pkg::TRIG1_SEL_BIT] && irq1_fall |=> stat_r[tmr_pins_pkg::PEND1_BIT])
    else $error("falling edge did not set pending one");
  a_gate_hold0: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ctrl_r[tmr_pins_pkg::TIMER_ZERO_GATING_SEL_SEL_BIT] && !irq0_lvl && !wr_pend_r |=> $stable(cnt0_r))
    else $error("timer zero ran while gated off");
  a_gate_hold1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ctrl_r[tmr_pins_pkg::TIMER_ONE_GATING_SEL_SEL_BIT] && !irq1_lvl && !wr_pend_r |=> $stable(cnt1_r))
    else $error("timer one ran while gated off");
  a_cnt_edge: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ctrl_r[tmr_pins_pkg::CNT0_MODE_BIT] && run0 && t0_fall && !wr_pend_r
    |=> cnt0_r == $past(cnt0_r) + 1'b1)
    else $error("count pin edge not counted");
  a_cnt_idle: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ctrl_r[tmr_pins_pkg::CNT0_MODE_BIT] && !t0_fall && !wr_pend_r |=> $stable(cnt0_r))
    else $error("counter moved without pin edge");
  a_irq_out: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    mask_r[tmr_pins_pkg::PEND0_BIT] && set_pend0 && !wr_pend_r |=> IRQ_O)
    else $error("unmasked pending zero did not raise interrupt");
  a_irq_out1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    mask_r[tmr_pins_pkg::PEND1_BIT] && set_pend1 && !wr_pend_r |=> IRQ_O)
    else $error("unmasked pending one did not raise interrupt");

  // Pin high then low on successive clocks
  sequence s_hi_lo0;
    irq0_lvl ##1 !irq0_lvl;
  endsequence : s_hi_lo0
  sequence s_hi_lo1;
    irq1_lvl ##1 !irq1_lvl;
  endsequence : s_hi_lo1
  sequence s_hi_lo_t0;
    t0_lvl ##1 !t0_lvl;
  endsequence : s_hi_lo_t0
  // Same, with the edge trigger or counter mode selected
  sequence s_edge0;
    ctrl_r[tmr_pins_pkg::TRIG0_SEL_BIT] && irq0_lvl ##1 ctrl_r[tmr_pins_pkg::TRIG0_SEL_BIT] && !irq0_lvl;
  endsequence : s_edge0
  sequence s_edge1;
    ctrl_r[tmr_pins_pkg::TRIG1_SEL_BIT] && irq1_lvl ##1 ctrl_r[tmr_pins_pkg::TRIG1_SEL_BIT] && !irq1_lvl;
  endsequence : s_edge1
  sequence s_cnt_edge;
    ctrl_r[tmr_pins_pkg::CNT0_MODE_BIT] && run0 && t0_lvl ##1 ctrl_r[tmr_pins_pkg::CNT0_MODE_BIT] && run0 && !t0_lvl && !wr_pend_r;
  endsequence : s_cnt_edge

  // Edge detect and synchroniser latency
  a_fall0_seen: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_hi_lo0 |-> irq0_fall)
    else $error("missed falling edge on irq pin zero");
  a_fall1_seen: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_hi_lo1 |-> irq1_fall)
    else $error("missed falling edge on irq pin one");
  a_fall_t0_seen: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_hi_lo_t0 |-> t0_fall)
    else $error("missed falling edge on count pin");
  a_lvl_sync0: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !$past(RST_I) && !$past(RST_I, 2)
    |-> irq0_lvl == $past(EXT_IRQ_ZERO_PIN_I, 2))
    else $error("irq pin zero level not two clocks late");
  a_lvl_sync1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !$past(RST_I) && !$past(RST_I, 2)
    |-> irq1_lvl == $past(EXT_IRQ_ONE_PIN_I, 2))
    else $error("irq pin one level not two clocks late");
  a_lvl_sync_t0: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !$past(RST_I) && !$past(RST_I, 2)
    |-> t0_lvl == $past(TIMER_ZERO_COUNT_PIN_I, 2))
    else $error("count pin level not two clocks late");

  // Sticky pending bits
  a_sticky0: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    stat_r[tmr_pins_pkg::PEND0_BIT] && !rd_stat |=> stat_r[tmr_pins_pkg::PEND0_BIT])
    else $error("pending zero lost without a read");
  a_sticky1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    stat_r[tmr_pins_pkg::PEND1_BIT] && !rd_stat |=> stat_r[tmr_pins_pkg::PEND1_BIT])
    else $error("pending one lost without a read");
  a_rd_clear0: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    rd_stat && !set_pend0 |=> !stat_r[tmr_pins_pkg::PEND0_BIT])
    else $error("read did not clear pending zero");
  a_rd_clear1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    rd_stat && !set_pend1 |=> !stat_r[tmr_pins_pkg::PEND1_BIT])
    else $error("read did not clear pending one");
  a_no_spur0: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !stat_r[tmr_pins_pkg::PEND0_BIT] && !set_pend0 |=> !stat_r[tmr_pins_pkg::PEND0_BIT])
    else $error("pending zero set without cause");
  a_no_spur1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !stat_r[tmr_pins_pkg::PEND1_BIT] && !set_pend1 |=> !stat_r[tmr_pins_pkg::PEND1_BIT])
    else $error("pending one set without cause");
  a_pend_rise0: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(stat_r[tmr_pins_pkg::PEND0_BIT]) |-> $past(set_pend0))
    else $error("pending zero rose without a set");
  a_pend_rise1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(stat_r[tmr_pins_pkg::PEND1_BIT]) |-> $past(set_pend1))
    else $error("pending one rose without a set");
  a_edge_seq0: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_edge0 |=> stat_r[tmr_pins_pkg::PEND0_BIT])
    else $error("high then low did not set pending zero");
  a_edge_seq1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_edge1 |=> stat_r[tmr_pins_pkg::PEND1_BIT])
    else $error("high then low did not set pending one");

  // Timer run control
  a_t0_timer: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !ctrl_r[tmr_pins_pkg::CNT0_MODE_BIT] && run0 && !wr_pend_r
    |=> cnt0_r == $past(cnt0_r) + 1'b1)
    else $error("running timer zero did not count");
  a_t0_stop: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !run0 && !wr_pend_r |=> $stable(cnt0_r))
    else $error("stopped timer zero moved");
  a_gate_run0: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ctrl_r[tmr_pins_pkg::RUN0_BIT] && ctrl_r[tmr_pins_pkg::TIMER_ZERO_GATING_SEL_SEL_BIT] && irq0_lvl
    && !ctrl_r[tmr_pins_pkg::CNT0_MODE_BIT] && !wr_pend_r |=> cnt0_r == $past(cnt0_r) + 1'b1)
    else $error("timer zero did not run with gate high");
  a_cnt_seq: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_cnt_edge |=> cnt0_r == $past(cnt0_r) + 1'b1)
    else $error("high then low on count pin not counted");
  a_t1_count: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    run1 && !wr_pend_r
    |=> cnt1_r == $past(cnt1_r) + 1'b1)
    else $error("running timer one did not count");
  a_t1_idle: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !run1 && !wr_pend_r |=> $stable(cnt1_r))
    else $error("stopped timer one moved");
  a_gate_run1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ctrl_r[tmr_pins_pkg::RUN1_BIT] && ctrl_r[tmr_pins_pkg::TIMER_ONE_GATING_SEL_SEL_BIT] && irq1_lvl
    && !wr_pend_r |=> cnt1_r == $past(cnt1_r) + 1'b1)
    else $error("timer one did not run with gate high");
  a_ovf0_set: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ovf0 |=> stat_r[tmr_pins_pkg::OVF0_BIT])
    else $error("timer zero wrap not flagged");
  a_ovf1_set: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ovf1 |=> stat_r[tmr_pins_pkg::OVF1_BIT])
    else $error("timer one wrap not flagged");
  a_ovf_rise1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(stat_r[tmr_pins_pkg::OVF1_BIT]) |-> $past(ovf1))
    else $error("timer one wrap flag rose without a wrap");

  // Register writes and read data
  a_wr_ctrl: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    wr_hit(wr_pend_r, wr_addr_r, tmr_pins_pkg::CTRL_OFS) |=> ctrl_r == $past(HWDATA_I[tmr_pins_pkg::CTRL_W-1:0]))
    else $error("control write did not land");
  a_wr_mask: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    wr_hit(wr_pend_r, wr_addr_r, tmr_pins_pkg::MASK_OFS) |=> mask_r == $past(HWDATA_I[tmr_pins_pkg::STAT_W-1:0]))
    else $error("mask write did not land");
  a_wr_cnt0: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    wr_hit(wr_pend_r, wr_addr_r, tmr_pins_pkg::CNT0_OFS) |=> cnt0_r == $past(HWDATA_I[CNT_W-1:0]))
    else $error("timer zero write did not land");
  a_wr_cnt1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    wr_hit(wr_pend_r, wr_addr_r, tmr_pins_pkg::CNT1_OFS) |=> cnt1_r == $past(HWDATA_I[CNT_W-1:0]))
    else $error("timer one write did not land");
  a_rd_ctrl: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    addr_ok && !HWRITE_I && HADDR_I[7:0] == tmr_pins_pkg::CTRL_OFS
    |=> HRDATA_O[tmr_pins_pkg::CTRL_W-1:0] == $past(ctrl_r))
    else $error("control read data wrong");
  a_rd_stat: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    addr_ok && !HWRITE_I && HADDR_I[7:0] == tmr_pins_pkg::STAT_OFS
    |=> HRDATA_O[tmr_pins_pkg::STAT_W-1:0] == $past(stat_r))
    else $error("status read data wrong");
  a_rd_mask: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    addr_ok && !HWRITE_I && HADDR_I[7:0] == tmr_pins_pkg::MASK_OFS
    |=> HRDATA_O[tmr_pins_pkg::STAT_W-1:0] == $past(mask_r))
    else $error("mask read data wrong");
  a_rd_cnt0: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    addr_ok && !HWRITE_I && HADDR_I[7:0] == tmr_pins_pkg::CNT0_OFS
    |=> HRDATA_O[CNT_W-1:0] == $past(cnt0_r))
    else $error("timer zero read data wrong");
  a_rd_cnt1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    addr_ok && !HWRITE_I && HADDR_I[7:0] == tmr_pins_pkg::CNT1_OFS
    |=> HRDATA_O[CNT_W-1:0] == $past(cnt1_r))
    else $error("timer one read data wrong");
  a_rdata_hold: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !(addr_ok && !HWRITE_I) |=> $stable(HRDATA_O))
    else $error("read data moved without a read");
endmodule : tmr_pins

// File: rtl/tmr_pins_pkg.sv
// Constants, register map and field layout for the timer gate and external interrupt input block
package tmr_pins_pkg;
  // Byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] CNT0_OFS = 8'h0c;
  localparam logic [7:0] CNT1_OFS = 8'h10;
  // Control register fields
  localparam int RUN0_BIT = 0;
  localparam int RUN1_BIT = 1;
  localparam int TIMER_ZERO_GATING_SEL_SEL_BIT = 2;
  localparam int TIMER_ONE_GATING_SEL_SEL_BIT = 3;
  localparam int TRIG0_SEL_BIT = 4;
  localparam int TRIG1_SEL_BIT = 5;
  localparam int CNT0_MODE_BIT = 6;
  localparam int CTRL_W = 7;
  // Status / mask fields
  localparam int PEND0_BIT = 0;
  localparam int PEND1_BIT = 1;
  localparam int OVF0_BIT = 2;
  localparam int OVF1_BIT = 3;
  localparam int STAT_W = 4;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [STAT_W-1:0] STAT_RST = 4'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 4'h0;
  localparam logic [15:0] CNT_RST = 16'h0000;
  // Synchroniser depth in cycles
  localparam int SYNC_STAGES = 2;
endpackage : tmr_pins_pkg
